// >>> rtl/sfbl_pkg.sv
`default_nettype none
package sfbl_pkg;

  localparam int          BYTE_W               = 8;
  localparam logic [2:0]  LAST_BIT             = 3'h7;
  localparam logic [2:0]  ID_HDR_LAST          = 3'h3;
  localparam logic [2:0]  ID_LAST              = 3'h6;
  localparam int          ID_BYTES             = 7;
  localparam int          ID_W                 = ID_BYTES * BYTE_W;
  localparam int          ADDR_W               = 24;
  localparam logic [3:0]  UART_LAST            = 4'h9;
  localparam int          CNT_W                = 16;
  localparam int          CLK_HZ               = 20_000_000;
  localparam int          BAUD_BPS             = 9600;
  localparam int          BAUD_DIV_DEFAULT     = CLK_HZ / BAUD_BPS;
  localparam int          BUF_DEPTH_DEFAULT    = 2;
  localparam logic [7:0]  TX_IDLE_BYTE         = 8'hFF;
  localparam logic [7:0]  CMD_READ_STATUS      = 8'h70;
  localparam logic [7:0]  CMD_ID_CHECK         = 8'hF5;
  localparam logic [7:0]  CMD_VERSION          = 8'hFB;
  localparam logic [23:0] USER_AREA_LO_DEFAULT = 24'h0F_0000;
  localparam logic [23:0] USER_AREA_HI_DEFAULT = 24'h0F_EFFF;

  typedef enum logic [1:0] {
    G_CMD    = 2'h0,
    G_PASS   = 2'h1,
    G_IDCODE = 2'h2,
    G_IDHDR  = 2'h3
  } sfbl_gate_t;

  typedef enum logic [1:0] {
    U_IDLE  = 2'h0,
    U_START = 2'h1,
    U_STOP  = 2'h2,
    U_DATA  = 2'h3
  } sfbl_uart_t;

  function automatic logic sfbl_cmd_open(input logic [7:0] code);
    return (code == CMD_READ_STATUS) || (code == CMD_ID_CHECK) || (code == CMD_VERSION);
  endfunction

  function automatic logic sfbl_in_user(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage
`default_nettype wire

// >>> rtl/sfbl_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - The serial clock entry pin is held high at power-up and afterwards serves as the serial input clock in mode 1.
// - Programming mode is entered at reset release when the clock entry pin is high and the high voltage is present.
// - At reset release the busy/select pin chooses mode 1 when high and mode 2 when low.
// - After entry the device drives the busy/select pin as an output.
// - Commands, addresses and data travel as 8-bit units over one serial channel.
// - In mode 1 the programmer supplies the transfer clock and the device generates none.
// - In mode 1 busy is low when ready to receive and goes high once a reception begins.
// - In mode 2 only the receive and transmit lines are used, with no clock and no busy handshake.
// - Only the user program area may be rewritten; the boot area is refused.
// - A 7-byte identification code must be presented to unlock commands.
// - With data in the flash, commands other than read status, ID check and version are rejected until a matching code has been received.
// - Each unit is sent least significant bit first.
// - In mode 1 bits are sampled on the rising clock edge and changed on the falling edge.
// - In mode 1 busy stays high during transfer, erase or program, and the programmer waits for it to fall.
module sfbl_top
  import sfbl_pkg::*;
#(
  parameter int          BAUD_DIV  = BAUD_DIV_DEFAULT,
  parameter int          BUF_DEPTH = BUF_DEPTH_DEFAULT,
  parameter logic [23:0] USER_LO   = USER_AREA_LO_DEFAULT,
  parameter logic [23:0] USER_HI   = USER_AREA_HI_DEFAULT
) (
  input  wire logic                CLK,
  input  wire logic                RESETN,
  input  wire logic                SERIAL_CLOCK_ENTRY_PIN,
  input  wire logic                MODE_ENTRY_HV,
  input  wire logic                BUSY_SELECT_IN,
  output logic                     BUSY_SELECT_OUT,
  output logic                     BUSY_SELECT_OE,
  input  wire logic                SERIAL_IN_PIN,
  output logic                     SERIAL_OUT_PIN,
  output logic                     PROG_MODE,
  output logic                     SYNC_MODE,
  output logic                     ID_OK,
  output logic [BYTE_W-1:0]        RX_DATA,
  output logic                     RX_VALID,
  input  wire logic                RX_READY,
  input  wire logic [BYTE_W-1:0]   TX_DATA,
  input  wire logic                TX_VALID,
  output logic                     TX_READY,
  input  wire logic                CMD_DONE,
  input  wire logic                FLASH_BLANK,
  input  wire logic                FLASH_BUSY,
  input  wire logic [ID_W-1:0]     ID_CODE,
  input  wire logic                REWRITE_REQ,
  input  wire logic [ADDR_W-1:0]   REWRITE_ADDR,
  output logic                     REWRITE_GRANT,
  output logic                     REWRITE_REJECT
);

  localparam logic [CNT_W-1:0] BIT_FULL = CNT_W'(BAUD_DIV - 1);
  localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(BAUD_DIV / 2 - 1);
  localparam int               PTR_W    = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PTR_W:0]   BUF_FULL = (PTR_W + 1)'(BUF_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? '0 : p + PTR_W'(1);
  endfunction

  logic                 prog_reg;
  logic                 sync_mode_reg;
  logic                 rel_reg;
  logic                 link_clr_reg;
  logic [5:0]           meta_reg;
  logic [5:0]           sync_reg;
  logic                 tog_prev_reg;
  logic                 lk_tog_reg;
  logic                 lk_act_reg;
  logic [2:0]           lk_cnt_reg;
  logic [2:0]           lk_idx_reg;
  logic                 lk_out_reg;
  logic [BYTE_W-1:0]    lk_sh_reg;
  logic [BYTE_W-1:0]    lk_data_reg;
  logic                 busy_reg;
  logic                 tx_full_reg;
  logic [BYTE_W-1:0]    tx_hold_reg;
  sfbl_uart_t           urx_st_reg;
  logic [CNT_W-1:0]     urx_cnt_reg;
  logic [2:0]           urx_bit_reg;
  logic [BYTE_W-1:0]    urx_sh_reg;
  logic                 urx_done_reg;
  sfbl_uart_t           utx_st_reg;
  logic [CNT_W-1:0]     utx_cnt_reg;
  logic [3:0]           utx_bit_reg;
  logic [BYTE_W+1:0]    utx_sh_reg;
  logic                 pend_reg;
  logic [BYTE_W-1:0]    pend_data_reg;
  sfbl_gate_t           gate_reg;
  logic [2:0]           idx_reg;
  logic                 mis_reg;
  logic                 id_ok_reg;
  logic [BYTE_W-1:0]    buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]     wr_ptr_reg;
  logic [PTR_W-1:0]     rd_ptr_reg;
  logic [PTR_W:0]       buf_cnt_reg;
  logic                 grant_reg;
  logic                 reject_reg;

  logic s_sclk, s_hv, s_busy, s_rxd, s_act, s_tog;
  logic lrx_evt, rx_evt, busy_next, unlocked, accept, push, drop, pop, buf_in_ready, byte_mis;
  logic [BYTE_W-1:0] rx_byte;

  // Pin levels and link-domain status reach CLK only through two flops; the resynchroniser
  // also runs during reset, so the oscillator cycles held under reset fill it.
  always_ff @(posedge CLK) begin
    meta_reg <= {lk_tog_reg, lk_act_reg, SERIAL_IN_PIN, BUSY_SELECT_IN, MODE_ENTRY_HV, SERIAL_CLOCK_ENTRY_PIN};
    sync_reg <= meta_reg;
  end

  assign s_sclk = sync_reg[0];
  assign s_hv   = sync_reg[1];
  assign s_busy = sync_reg[2];
  assign s_rxd  = sync_reg[3];
  assign s_act  = sync_reg[4];
  assign s_tog  = sync_reg[5];

  // Entry and mode choice are caught once, on the first clock after release.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rel_reg       <= 1'h0;
      prog_reg      <= 1'h0;
      sync_mode_reg <= 1'h0;
    end else if (!rel_reg) begin
      rel_reg       <= 1'h1;
      prog_reg      <= s_sclk & s_hv;
      sync_mode_reg <= s_busy;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      link_clr_reg <= 1'h1;
      tog_prev_reg <= 1'h0;
    end else begin
      link_clr_reg <= !(prog_reg & sync_mode_reg);
      tog_prev_reg <= s_tog;
    end
  end

  // The link clock only runs inside frames, so the clear is asynchronous: it is released
  // while the programmer still holds the clock quiet, waiting for busy to fall.
  always_ff @(posedge SERIAL_CLOCK_ENTRY_PIN or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      lk_cnt_reg  <= 3'h0;
      lk_act_reg  <= 1'h0;
      lk_tog_reg  <= 1'h0;
      lk_sh_reg   <= '0;
      lk_data_reg <= '0;
    end else begin
      lk_sh_reg  <= {SERIAL_IN_PIN, lk_sh_reg[BYTE_W-1:1]};
      lk_cnt_reg <= lk_cnt_reg + 3'h1;
      lk_act_reg <= (lk_cnt_reg != LAST_BIT);
      if (lk_cnt_reg == LAST_BIT) begin
        lk_data_reg <= {SERIAL_IN_PIN, lk_sh_reg[BYTE_W-1:1]};
        lk_tog_reg  <= !lk_tog_reg;
      end
    end
  end

  // Transmit bits move on the falling edge, so bit 0 is out before the first sampling edge.
  // The byte itself is held in CLK and must not be loaded while a frame runs.
  always_ff @(negedge SERIAL_CLOCK_ENTRY_PIN or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      lk_idx_reg <= 3'h0;
      lk_out_reg <= 1'h1;
    end else begin
      lk_out_reg <= tx_hold_reg[lk_idx_reg];
      lk_idx_reg <= lk_idx_reg + 3'h1;
    end
  end

  assign lrx_evt = s_tog ^ tog_prev_reg;

  always_ff @(posedge CLK) begin
    if (!RESETN || !prog_reg || sync_mode_reg) begin
      urx_st_reg   <= U_IDLE;
      urx_cnt_reg  <= '0;
      urx_bit_reg  <= 3'h0;
      urx_sh_reg   <= '0;
      urx_done_reg <= 1'h0;
    end else begin
      urx_done_reg <= 1'h0;
      case (urx_st_reg)
        U_IDLE: begin
          if (!s_rxd) begin
            urx_st_reg  <= U_START;
            urx_cnt_reg <= BIT_HALF;
          end
        end
        U_START: begin
          if (urx_cnt_reg != '0) begin
            urx_cnt_reg <= urx_cnt_reg - CNT_W'(1);
          end else if (!s_rxd) begin
            urx_st_reg  <= U_DATA;
            urx_cnt_reg <= BIT_FULL;
            urx_bit_reg <= 3'h0;
          end else begin
            urx_st_reg <= U_IDLE;
          end
        end
        U_DATA: begin
          if (urx_cnt_reg != '0) begin
            urx_cnt_reg <= urx_cnt_reg - CNT_W'(1);
          end else begin
            urx_sh_reg  <= {s_rxd, urx_sh_reg[BYTE_W-1:1]};
            urx_cnt_reg <= BIT_FULL;
            urx_bit_reg <= urx_bit_reg + 3'h1;
            if (urx_bit_reg == LAST_BIT) begin
              urx_st_reg <= U_STOP;
            end
          end
        end
        U_STOP: begin
          if (urx_cnt_reg != '0) begin
            urx_cnt_reg <= urx_cnt_reg - CNT_W'(1);
          end else begin
            urx_done_reg <= s_rxd;
            urx_st_reg   <= U_IDLE;
          end
        end
        default: urx_st_reg <= U_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN || !prog_reg || sync_mode_reg) begin
      utx_st_reg  <= U_IDLE;
      utx_cnt_reg <= '0;
      utx_bit_reg <= 4'h0;
      utx_sh_reg  <= '1;
    end else begin
      case (utx_st_reg)
        U_IDLE: begin
          if (TX_VALID) begin
            utx_sh_reg  <= {1'h1, TX_DATA, 1'h0};
            utx_cnt_reg <= BIT_FULL;
            utx_bit_reg <= 4'h0;
            utx_st_reg  <= U_DATA;
          end
        end
        U_DATA: begin
          if (utx_cnt_reg != '0) begin
            utx_cnt_reg <= utx_cnt_reg - CNT_W'(1);
          end else begin
            utx_sh_reg  <= {1'h1, utx_sh_reg[BYTE_W+1:1]};
            utx_cnt_reg <= BIT_FULL;
            utx_bit_reg <= utx_bit_reg + 4'h1;
            if (utx_bit_reg == UART_LAST) begin
              utx_st_reg <= U_IDLE;
            end
          end
        end
        default: utx_st_reg <= U_IDLE;
      endcase
    end
  end

  // Mode-1 transmit byte: loaded only while busy is high, released after the frame.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tx_full_reg <= 1'h0;
      tx_hold_reg <= TX_IDLE_BYTE;
    end else if (TX_VALID && TX_READY && sync_mode_reg) begin
      tx_full_reg <= 1'h1;
      tx_hold_reg <= TX_DATA;
    end else if (lrx_evt) begin
      tx_full_reg <= 1'h0;
      tx_hold_reg <= TX_IDLE_BYTE;
    end
  end

  assign TX_READY = prog_reg & (sync_mode_reg ? (!tx_full_reg & busy_reg) : (utx_st_reg == U_IDLE));

  // Busy covers a cleared link, a running frame, flash work, a byte not yet taken and a pending load.
  assign busy_next = link_clr_reg | s_act | lrx_evt | FLASH_BUSY | pend_reg | !buf_in_ready | (TX_VALID & !tx_full_reg);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      busy_reg <= 1'h1;
    end else begin
      busy_reg <= busy_next;
    end
  end

  assign BUSY_SELECT_OE  = prog_reg;
  assign BUSY_SELECT_OUT = prog_reg & sync_mode_reg & busy_reg;
  assign SERIAL_OUT_PIN  = sync_mode_reg ? lk_out_reg : utx_sh_reg[0];

  assign rx_evt  = prog_reg & (sync_mode_reg ? lrx_evt : urx_done_reg);
  assign rx_byte = sync_mode_reg ? lk_data_reg : urx_sh_reg;

  // A byte arriving as the previous one is consumed keeps the flag set; an unconsumed one is overwritten.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pend_reg      <= 1'h0;
      pend_data_reg <= '0;
    end else if (rx_evt) begin
      pend_reg      <= 1'h1;
      pend_data_reg <= rx_byte;
    end else if (push || drop) begin
      pend_reg <= 1'h0;
    end
  end

  assign unlocked = id_ok_reg | FLASH_BLANK;
  assign accept   = unlocked | sfbl_cmd_open(pend_data_reg);
  assign push     = pend_reg & ((gate_reg != G_CMD) | accept) & buf_in_ready;
  assign drop     = pend_reg & (gate_reg == G_CMD) & !accept;
  assign byte_mis = pend_data_reg != ID_CODE[{idx_reg, 3'h0} +: BYTE_W];

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      gate_reg  <= G_CMD;
      idx_reg   <= 3'h0;
      mis_reg   <= 1'h0;
      id_ok_reg <= 1'h0;
    end else begin
      case (gate_reg)
        G_CMD: begin
          if (push) begin
            gate_reg <= (pend_data_reg == CMD_ID_CHECK) ? G_IDHDR : G_PASS;
            idx_reg  <= 3'h0;
          end
        end
        G_PASS: begin
          if (CMD_DONE) begin
            gate_reg <= G_CMD;
          end
        end
        G_IDHDR: begin
          if (push && idx_reg == ID_HDR_LAST) begin
            gate_reg <= G_IDCODE;
            idx_reg  <= 3'h0;
            mis_reg  <= 1'h0;
          end else if (push) begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        G_IDCODE: begin
          if (push && idx_reg == ID_LAST) begin
            id_ok_reg <= !(mis_reg | byte_mis);
            gate_reg  <= G_CMD;
          end else if (push) begin
            mis_reg <= mis_reg | byte_mis;
            idx_reg <= idx_reg + 3'h1;
          end
        end
        default: gate_reg <= G_CMD;
      endcase
    end
  end

  assign buf_in_ready = buf_cnt_reg != BUF_FULL;
  assign pop          = RX_VALID & RX_READY;

  always_ff @(posedge CLK) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= pend_data_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      buf_cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_next(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_next(rd_ptr_reg);
      end
      buf_cnt_reg <= buf_cnt_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end
  end

  assign RX_VALID = buf_cnt_reg != '0;
  assign RX_DATA  = buf_mem[rd_ptr_reg];

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      grant_reg  <= 1'h0;
      reject_reg <= 1'h0;
    end else begin
      grant_reg  <= REWRITE_REQ & prog_reg & sfbl_in_user(REWRITE_ADDR, USER_LO, USER_HI);
      reject_reg <= REWRITE_REQ & !(prog_reg & sfbl_in_user(REWRITE_ADDR, USER_LO, USER_HI));
    end
  end

  assign REWRITE_GRANT  = grant_reg;
  assign REWRITE_REJECT = reject_reg;
  assign PROG_MODE      = prog_reg;
  assign SYNC_MODE      = sync_mode_reg;
  assign ID_OK          = id_ok_reg;

  property p_mode_hold;
    @(posedge CLK) disable iff (!RESETN) rel_reg |=> $stable(sync_mode_reg) && $stable(prog_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("Mode changed after release.");

  property p_entry;
    @(posedge CLK) disable iff (!RESETN) $rose(rel_reg) |-> prog_reg == $past(s_sclk & s_hv);
  endproperty
  a_entry: assert property (p_entry) else $error("Entry decision wrong.");

  property p_select;
    @(posedge CLK) disable iff (!RESETN) $rose(rel_reg) |-> sync_mode_reg == $past(s_busy);
  endproperty
  a_select: assert property (p_select) else $error("Mode selection wrong.");

  property p_drive;
    @(posedge CLK) disable iff (!RESETN) $rose(prog_reg) |-> BUSY_SELECT_OE [*3];
  endproperty
  a_drive: assert property (p_drive) else $error("Busy pin not driven after entry.");

  property p_busy_rx;
    @(posedge CLK) disable iff (!RESETN) (prog_reg && sync_mode_reg && s_act) |=> BUSY_SELECT_OUT;
  endproperty
  a_busy_rx: assert property (p_busy_rx) else $error("Busy low during reception.");

  property p_busy_flash;
    @(posedge CLK) disable iff (!RESETN) (prog_reg && sync_mode_reg && FLASH_BUSY) |=> BUSY_SELECT_OUT;
  endproperty
  a_busy_flash: assert property (p_busy_flash) else $error("Busy low during flash work.");

  property p_mode2;
    @(posedge CLK) disable iff (!RESETN) (prog_reg && !sync_mode_reg) |-> !BUSY_SELECT_OUT && link_clr_reg ##1 1'h1;
  endproperty
  a_mode2: assert property (p_mode2) else $error("Mode 2 uses busy or clock.");

  property p_gate;
    @(posedge CLK) disable iff (!RESETN)
      (push && gate_reg == G_CMD && !FLASH_BLANK && !id_ok_reg) |-> sfbl_cmd_open(pend_data_reg);
  endproperty
  a_gate: assert property (p_gate) else $error("Locked command accepted.");

  property p_id_ok;
    @(posedge CLK) disable iff (!RESETN) $rose(id_ok_reg) |-> $past(gate_reg == G_IDCODE && idx_reg == ID_LAST && push);
  endproperty
  a_id_ok: assert property (p_id_ok) else $error("Code accepted without seven bytes.");

  property p_rewrite;
    @(posedge CLK) disable iff (!RESETN)
      (REWRITE_REQ && !sfbl_in_user(REWRITE_ADDR, USER_LO, USER_HI)) |=> !REWRITE_GRANT && REWRITE_REJECT;
  endproperty
  a_rewrite: assert property (p_rewrite) else $error("Boot area rewrite granted.");

endmodule
`default_nettype wire

// >>> testbench/sfbl_prog_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfbl_prog_host #(
  parameter int BIT_NS = 200
) (
  output logic     link_clk,
  output logic     data_out,
  input  wire logic data_in,
  input  wire logic busy
);
  initial begin
    link_clk = 1'b1;
    data_out = 1'b1;
  end

  task automatic line_idle();
    data_out = 1'b1;
  endtask

  // The link clock moves only inside a frame, so the device never sees a stray edge.
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx, output logic seen, output bit ok);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      #10;
      n++;
    end
    ok = (n < 400);
    for (int i = 0; i < 8; i++) begin
      link_clk = 1'b0;
      data_out = tx[i];
      #15;
      link_clk = 1'b1;
      rx[i] = data_in;
      #15;
    end
    seen = busy;
    data_out = ~tx[7];
  endtask

  task automatic uart_send(input logic [7:0] tx);
    data_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      data_out = tx[i];
      #(BIT_NS);
    end
    data_out = 1'b1;
    #(BIT_NS);
  endtask

  task automatic uart_recv(output logic [7:0] rx, output bit ok);
    int n;
    n = 0;
    while (data_in !== 1'b0 && n < 4000) begin
      #5;
      n++;
    end
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      rx[i] = data_in;
    end
    #(BIT_NS);
    ok = (n < 4000) && (data_in === 1'b1);
  endtask
endmodule
`default_nettype wire

// >>> testbench/sfbl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sfbl_bench;
  import sfbl_pkg::*;
  localparam logic [55:0] ID_VAL = 56'h1E2D3C4B5A6978;
  logic        clk = 1'b0, resetn = 1'b0, hv = 1'b0, sel_drive = 1'b1, rx_ready = 1'b1;
  logic        tx_valid = 1'b0, cmd_done = 1'b0, req = 1'b0, flash_blank = 1'b0, flash_busy = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic        sclk, sin, sout, busy_out, busy_oe, prog, sync, id_ok;
  logic        rx_valid, tx_ready, grant, reject;
  logic [7:0]  rx_data;
  logic [7:0]  rx_q[$];
  int          num_errors = 0;
  int          total_checks = 0;
  wire logic   busy_pin = busy_oe ? busy_out : sel_drive;

  always #25 clk = ~clk;

  sfbl_top #(.BAUD_DIV(4), .BUF_DEPTH(2)) DUT (
    .CLK                    (clk),
    .RESETN                 (resetn),
    .SERIAL_CLOCK_ENTRY_PIN (sclk),
    .MODE_ENTRY_HV          (hv),
    .BUSY_SELECT_IN         (busy_pin),
    .BUSY_SELECT_OUT        (busy_out),
    .BUSY_SELECT_OE         (busy_oe),
    .SERIAL_IN_PIN          (sin),
    .SERIAL_OUT_PIN         (sout),
    .PROG_MODE              (prog),
    .SYNC_MODE              (sync),
    .ID_OK                  (id_ok),
    .RX_DATA                (rx_data),
    .RX_VALID               (rx_valid),
    .RX_READY               (rx_ready),
    .TX_DATA                (tx_data),
    .TX_VALID               (tx_valid),
    .TX_READY               (tx_ready),
    .CMD_DONE               (cmd_done),
    .FLASH_BLANK            (flash_blank),
    .FLASH_BUSY             (flash_busy),
    .ID_CODE                (ID_VAL),
    .REWRITE_REQ            (req),
    .REWRITE_ADDR           (addr),
    .REWRITE_GRANT          (grant),
    .REWRITE_REJECT         (reject)
  );

  sfbl_prog_host #(.BIT_NS(200)) host (
    .link_clk (sclk),
    .data_out (sin),
    .data_in  (sout),
    .busy     (busy_pin)
  );

  always @(posedge clk) begin
    if (resetn && rx_valid === 1'b1 && rx_ready) begin
      rx_q.push_back(rx_data);
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    num_errors++;
    $display("ERROR %s expected done seen timeout", what);
    finish_test();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic enter(input logic hv_v, input logic sel_v);
    resetn = 1'b0;
    hv = hv_v;
    sel_drive = sel_v;
    host.line_idle();
    tick(24);
    resetn = 1'b1;
    rx_q.delete();
    tick(4);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] got);
    logic seen;
    bit   ok;
    host.frame(tx, got, seen, ok);
    if (!ok) give_up("busy_wait");
    check("busy_in_frame", 8'h01, {7'h00, seen});
  endtask

  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 400) begin
      tick(1);
      n++;
    end
    if (rx_q.size() == 0) give_up("rx_data");
    check("rx_data", exp, rx_q.pop_front());
  endtask

  // Valid is held up until ready is seen, so the byte cannot slip past a late ready.
  task automatic push_tx(input logic [7:0] b);
    int n;
    n = 0;
    tx_data = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) give_up("tx_ready");
    tick(1);
    tx_valid = 1'b0;
  endtask

  task automatic s_no_entry();
    enter(1'b0, 1'b1);
    check("prog_mode", 8'h00, {7'h00, prog});
    check("busy_oe", 8'h00, {7'h00, busy_oe});
  endtask

  task automatic s_sync_link();
    logic [7:0] got;
    enter(1'b1, 1'b1);
    check("prog_mode", 8'h01, {7'h00, prog});
    check("sync_mode", 8'h01, {7'h00, sync});
    check("busy_oe", 8'h01, {7'h00, busy_oe});
    xfer(8'h41, got);
    check("idle_byte", TX_IDLE_BYTE, got);
    tick(20);
    check("dropped", 8'h00, 8'(rx_q.size()));
    push_tx(8'hA5);
    xfer(CMD_READ_STATUS, got);
    check("tx_byte", 8'hA5, got);
    take(CMD_READ_STATUS);
    rx_ready = 1'b0;
    xfer(8'h11, got);
    check("idle_after", TX_IDLE_BYTE, got);
    xfer(8'h22, got);
    tick(12);
    check("busy_full", 8'h01, {7'h00, busy_out});
    rx_ready = 1'b1;
    take(8'h11);
    take(8'h22);
    flash_busy = 1'b1;
    tick(4);
    check("busy_flash", 8'h01, {7'h00, busy_out});
    flash_busy = 1'b0;
    check("sync_kept", 8'h01, {7'h00, sync});
  endtask

  task automatic send_id(input logic [55:0] code);
    logic [7:0] got;
    xfer(CMD_ID_CHECK, got);
    repeat (4) xfer(8'h00, got);
    for (int i = 0; i < ID_BYTES; i++) begin
      xfer(code[8*i +: 8], got);
    end
    tick(20);
  endtask

  task automatic s_id_gate();
    logic [7:0] got;
    cmd_done = 1'b1;
    tick(1);
    cmd_done = 1'b0;
    send_id(ID_VAL ^ 56'h01000000000000);
    check("id_bad", 8'h00, {7'h00, id_ok});
    send_id(ID_VAL);
    check("id_good", 8'h01, {7'h00, id_ok});
    rx_q.delete();
    xfer(8'h41, got);
    take(8'h41);
  endtask

  task automatic s_rewrite();
    logic [23:0] a[4] = '{USER_AREA_LO_DEFAULT - 24'h1, USER_AREA_LO_DEFAULT,
                          USER_AREA_HI_DEFAULT, USER_AREA_HI_DEFAULT + 24'h1};
    logic [1:0]  e[4] = '{2'h1, 2'h2, 2'h2, 2'h1};
    req = 1'b1;
    for (int i = 0; i < 4; i++) begin
      addr = a[i];
      tick(1);
      check("rewrite", {6'h00, e[i]}, {6'h00, grant, reject});
    end
    req = 1'b0;
  endtask

  task automatic s_async_link();
    logic [7:0] got;
    bit         ok;
    enter(1'b1, 1'b0);
    check("sync_mode", 8'h00, {7'h00, sync});
    check("busy_oe", 8'h01, {7'h00, busy_oe});
    check("busy_low", 8'h00, {7'h00, busy_out});
    host.uart_send(CMD_READ_STATUS);
    take(CMD_READ_STATUS);
    fork
      host.uart_recv(got, ok);
      push_tx(8'h3C);
    join
    check("uart_tx", 8'h3C, got);
    check("uart_stop", 8'h01, {7'h00, ok});
    cmd_done = 1'b1;
    tick(1);
    cmd_done = 1'b0;
    flash_blank = 1'b1;
    host.uart_send(8'h41);
    take(8'h41);
    flash_blank = 1'b0;
  endtask

  initial begin
    s_no_entry();
    s_sync_link();
    s_id_gate();
    s_rewrite();
    s_async_link();
    finish_test();
  end
endmodule
`default_nettype wire
